// ==== core/cwp_pkg.sv ====
package cwp_pkg;
  // ****************************************
  // configuration space word addresses
  // ****************************************
  localparam logic [15:0] ADDR_REVISION = 16'h8005;
  localparam logic [15:0] ADDR_PART_ID = 16'h8006;
  localparam logic [15:0] ADDR_CFG2 = 16'h8008;
  localparam logic [15:0] ADDR_CFG3 = 16'h8009;
  localparam logic [15:0] ADDR_CFG4 = 16'h800A;
  localparam logic [15:0] ADDR_CFG5 = 16'h800B;
  localparam logic [15:0] ADDR_CFG_LO = 16'h8007;
  localparam logic [15:0] ADDR_CFG_HI = 16'h800B;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG2_DELAY_SEL_LSB = 1;
  localparam int CFG2_RSTPIN_BIT = 0;
  localparam int CFG4_LV_PROG_BIT = 13;
  localparam int CFG4_STORE_WP_BIT = 11;
  localparam int CFG4_CFG_WP_BIT = 9;
  localparam int CFG4_BOOT_WP_BIT = 8;
  localparam int CFG4_APP_WP_BIT = 7;
  localparam int CFG4_STORE_EN_N_BIT = 4;
  localparam int CFG4_BOOT_EN_N_BIT = 3;
  localparam int CFG5_PROTECT_N_BIT = 0;
  localparam logic [13:0] CFG4_STICKY = 14'h0B80;
  // ****************************************
  // erased (reset) values and identity
  // ****************************************
  localparam logic [13:0] WORD_ERASED = 14'h3FFF;
  localparam logic [13:0] CFG5_ERASED = 14'h0001;
  localparam logic [11:0] PART_CODE = 12'hA5C; // arbitrary value
  localparam logic [5:0] MAJOR_REV = 6'h01; // arbitrary value
  localparam logic [5:0] MINOR_REV = 6'h02; // arbitrary value
  localparam logic [1:0] PART_ID_TOP = 2'h3;
  localparam logic [1:0] REV_ID_TOP = 2'h2;
  // ****************************************
  // memory map
  // ****************************************
  localparam logic [14:0] FLASH_LAST = 15'h0FFF;
  localparam logic [14:0] FLASH_HALF_END = 15'h07FF;
  localparam logic [14:0] STORE_WORDS = 15'h0080;
  // ****************************************
  // power-up delay times
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int DELAY_LONG_MS = 16;
  localparam int DELAY_SHORT_MS = 1;
  localparam int DELAY_MID_MS = 64;
  localparam int DELAY_LONG_CYC = DELAY_LONG_MS * 1000 * CLK_MHZ;
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * 1000 * CLK_MHZ;
  localparam int DELAY_MID_CYC = DELAY_MID_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    CWP_RGN_BOOT = 2'h0,
    CWP_RGN_APP = 2'h1,
    CWP_RGN_STORE = 2'h3,
    CWP_RGN_CFG = 2'h2
  } cwp_region_t;
  typedef enum logic [1:0] {
    CWP_IDLE = 2'h0,
    CWP_CHECK = 2'h1,
    CWP_DONE = 2'h3
  } cwp_state_t;
endpackage

// ==== core/cwp_map_if.sv ====
`timescale 1ns/1ps
interface cwp_map_if;
  logic [14:0] boot_end;
  logic boot_en;
  logic store_en;
  logic [15:0] addr;
  cwp_pkg::cwp_region_t region;
  logic in_cfg;
  modport cfg (output boot_end, output boot_en, output store_en, output addr, input region, input in_cfg);
  modport map (input boot_end, input boot_en, input store_en, input addr, output region, output in_cfg);
endinterface

// ==== core/cwp_region_map.sv ====
`timescale 1ns/1ps
module cwp_region_map (
  // decode channel
  cwp_map_if.map m
);
  wire [14:0] a15 = m.addr[14:0];
  wire cfg_hit = m.addr >= cwp_pkg::ADDR_CFG_LO && m.addr <= cwp_pkg::ADDR_CFG_HI;
  wire store_hit = m.store_en && a15 > (cwp_pkg::FLASH_LAST - cwp_pkg::STORE_WORDS);
  wire boot_hit = m.boot_en && a15 <= m.boot_end;
  assign m.in_cfg = cfg_hit;
  // configuration first, storage area next since it overrides the top of the application
  assign m.region = cfg_hit ? cwp_pkg::CWP_RGN_CFG : store_hit ? cwp_pkg::CWP_RGN_STORE :
                    boot_hit ? cwp_pkg::CWP_RGN_BOOT : cwp_pkg::CWP_RGN_APP;
endmodule // cwp_region_map

// ==== core/cwp_config_protect.sv ====
`timescale 1ns/1ps
// Functional notes
// - code 01 gives 16 ms, 00 1 ms
// - low-voltage programming forces pin to reset
// - else reset-pin enable picks reset or port
// - refuse clearing low-voltage enable during low-voltage session
// - bit 11 low protects storage area
// - bit 9 low protects configuration words
// - bit 8 low protects enabled boot block
// - bit 7 low protects application block
// - cleared protection returns only by bulk erase
// - bit 4 low enables storage area
// - bit 3 low enables boot block
// - boot size code sets boot end address
// - boot size clamped to half flash
// - boot size changeable only while boot disabled
// - code protect low, removed only by erase
// - part word read-only, top bits one
// - revision word read-only, major and minor fields
// - code protect blocks external flash access, zeros
// - protected write ignored, sets write error flag
// - storage area is last 128 words, no execution
module cwp_config_protect (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // nonvolatile word write and read port
  input wire logic wr_req,
  input wire logic wr_external,
  input wire logic [15:0] wr_addr,
  input wire logic [13:0] wr_data,
  input wire logic bulk_erase,
  input wire logic rd_req,
  input wire logic rd_external,
  input wire logic [15:0] rd_addr,
  input wire logic [13:0] flash_rd_data,
  input wire logic lv_session_pin,
  input wire logic fetch_req,
  input wire logic [14:0] fetch_addr,
  // results
  output logic [13:0] rd_data,
  output logic rd_valid,
  output logic flash_wr_en,
  output logic write_error_flag,
  output logic wr_done,
  output logic fetch_violation,
  // decoded configuration
  output logic external_reset_pin,
  output logic powerup_delay_timer,
  output logic [1:0] powerup_delay_select,
  output logic [14:0] boot_end_addr,
  output logic code_protect_active
);
  // ****************************************
  // stored configuration words
  // ****************************************
  logic [13:0] cfg2_q, cfg4_q, cfg5_q;
  logic [1:0] lv_sync_q;
  logic rst_pin_q, delay_busy_q, protect_q;
  logic [14:0] bend_q;
  logic [1:0] pwsel_q;
  logic [13:0] rd_data_q;
  logic rd_valid_q, fwe_q, err_q, done_q, fv_q;
  logic [23:0] delay_cnt_q;
  logic started_q;
  cwp_pkg::cwp_state_t st_q;
  logic [15:0] wa_q;
  logic [13:0] wd_q;
  logic wext_q;
  // ****************************************
  // decode
  // ****************************************
  function automatic logic [14:0] boot_end_of(input logic [2:0] code);
    logic [14:0] e;
    e = 15'h3FFF;
    case (code)
      3'h7: e = 15'h01FF;
      3'h6: e = 15'h03FF;
      3'h5: e = 15'h07FF;
      3'h4: e = 15'h0FFF;
      3'h3: e = 15'h1FFF;
      default: e = 15'h3FFF;
    endcase
    if (e > cwp_pkg::FLASH_HALF_END) begin
      e = cwp_pkg::FLASH_HALF_END;
    end
    return e;
  endfunction
  wire lv_prog_on = cfg4_q[cwp_pkg::CFG4_LV_PROG_BIT];
  wire store_en = ~cfg4_q[cwp_pkg::CFG4_STORE_EN_N_BIT];
  wire boot_en = ~cfg4_q[cwp_pkg::CFG4_BOOT_EN_N_BIT];
  wire protect_on = ~cfg5_q[cwp_pkg::CFG5_PROTECT_N_BIT];
  wire lv_session = lv_sync_q[1];
  wire [1:0] pw_code = cfg2_q[cwp_pkg::CFG2_DELAY_SEL_LSB +: 2];
  wire [23:0] pw_cycles = (pw_code == 2'h1) ? 24'(cwp_pkg::DELAY_LONG_CYC) :
                          (pw_code == 2'h0) ? 24'(cwp_pkg::DELAY_SHORT_CYC) :
                          (pw_code == 2'h2) ? 24'(cwp_pkg::DELAY_MID_CYC) : 24'h000000;
  wire rst_pin_d = lv_prog_on | cfg2_q[cwp_pkg::CFG2_RSTPIN_BIT];
  cwp_map_if mif ();
  assign mif.boot_end = bend_q;
  assign mif.boot_en = boot_en;
  assign mif.store_en = store_en;
  assign mif.addr = wa_q;
  cwp_region_map u_map (
    .m(mif.map)
  );
  wire prot_hit =
    (mif.region == cwp_pkg::CWP_RGN_CFG && !cfg4_q[cwp_pkg::CFG4_CFG_WP_BIT]) ||
    (mif.region == cwp_pkg::CWP_RGN_STORE && !cfg4_q[cwp_pkg::CFG4_STORE_WP_BIT]) ||
    (mif.region == cwp_pkg::CWP_RGN_BOOT && !cfg4_q[cwp_pkg::CFG4_BOOT_WP_BIT]) ||
    (mif.region == cwp_pkg::CWP_RGN_APP && !cfg4_q[cwp_pkg::CFG4_APP_WP_BIT]);
  wire protect_block = wext_q && protect_on && !mif.in_cfg;
  wire wr_refused = prot_hit || protect_block;
  // protection bits can only be cleared; only erase sets them, so AND with old value
  wire [13:0] cfg4_prot = (cfg4_q & cwp_pkg::CFG4_STICKY & wd_q) | (wd_q & ~cwp_pkg::CFG4_STICKY);
  wire [13:0] cfg4_lv = (lv_session && lv_prog_on) ? (cfg4_prot | 14'h2000) : cfg4_prot;
  wire [13:0] cfg4_next = boot_en ? {cfg4_lv[13:3], cfg4_q[2:0]} : cfg4_lv;
  wire [13:0] cfg5_next = {wd_q[13:1], cfg5_q[0] & wd_q[0]};
  wire is_cfg4 = wa_q == cwp_pkg::ADDR_CFG4;
  wire is_cfg5 = wa_q == cwp_pkg::ADDR_CFG5;
  wire is_cfg2 = wa_q == cwp_pkg::ADDR_CFG2;
  wire rd_id = rd_addr == cwp_pkg::ADDR_PART_ID;
  wire rd_rev = rd_addr == cwp_pkg::ADDR_REVISION;
  wire [13:0] rd_mux = rd_id ? {cwp_pkg::PART_ID_TOP, cwp_pkg::PART_CODE} :
                       rd_rev ? {cwp_pkg::REV_ID_TOP, cwp_pkg::MAJOR_REV, cwp_pkg::MINOR_REV} :
                       (rd_addr == cwp_pkg::ADDR_CFG2) ? cfg2_q :
                       (rd_addr == cwp_pkg::ADDR_CFG4) ? cfg4_q :
                       (rd_addr == cwp_pkg::ADDR_CFG5) ? cfg5_q :
                       (rd_addr == cwp_pkg::ADDR_CFG3) ? 14'h0000 :
                       (rd_external && protect_on && !rd_addr[15]) ? 14'h0000 : flash_rd_data;
  wire fetch_store = store_en && fetch_addr > (cwp_pkg::FLASH_LAST - cwp_pkg::STORE_WORDS);
  // ****************************************
  // write sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= cwp_pkg::CWP_IDLE;
      wa_q <= 16'h0000;
      wd_q <= 14'h0000;
      wext_q <= 1'b0;
    end else begin
      case (st_q)
        cwp_pkg::CWP_IDLE: begin
          if (wr_req && !bulk_erase) begin
            st_q <= cwp_pkg::CWP_CHECK;
            wa_q <= wr_addr;
            wd_q <= wr_data;
            wext_q <= wr_external;
          end
        end
        cwp_pkg::CWP_CHECK: st_q <= cwp_pkg::CWP_DONE;
        cwp_pkg::CWP_DONE: st_q <= cwp_pkg::CWP_IDLE;
        default: st_q <= cwp_pkg::CWP_IDLE;
      endcase
    end
  end
  wire checking = st_q == cwp_pkg::CWP_CHECK;
  wire commit = checking && !wr_refused;
  // ****************************************
  // configuration storage
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn || bulk_erase) begin
      cfg2_q <= cwp_pkg::WORD_ERASED;
      cfg4_q <= cwp_pkg::WORD_ERASED;
      cfg5_q <= cwp_pkg::WORD_ERASED;
    end else if (commit) begin
      if (is_cfg2) begin
        cfg2_q <= wd_q;
      end
      if (is_cfg4) begin
        cfg4_q <= cfg4_next;
      end
      if (is_cfg5) begin
        cfg5_q <= cfg5_next;
      end
    end
  end
  // ****************************************
  // status and outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lv_sync_q <= 2'h0;
      err_q <= 1'b0;
      fwe_q <= 1'b0;
      done_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 14'h0000;
      fv_q <= 1'b0;
      rst_pin_q <= 1'b1;
      pwsel_q <= 2'h3;
      bend_q <= cwp_pkg::FLASH_HALF_END;
      protect_q <= 1'b0;
    end else begin
      lv_sync_q <= {lv_sync_q[0], lv_session_pin};
      // sticky until a new write starts; the error of that write wins
      err_q <= (checking && wr_refused) || (err_q && !(wr_req && st_q == cwp_pkg::CWP_IDLE));
      fwe_q <= commit && !wa_q[15];
      done_q <= checking;
      rd_valid_q <= rd_req;
      rd_data_q <= rd_req ? rd_mux : rd_data_q;
      fv_q <= fetch_req && fetch_store;
      rst_pin_q <= rst_pin_d;
      pwsel_q <= pw_code;
      bend_q <= boot_end_of(cfg4_q[2:0]);
      protect_q <= protect_on;
    end
  end
  // power-up delay evaluated once after reset release
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      delay_cnt_q <= 24'h000000;
      started_q <= 1'b0;
      delay_busy_q <= 1'b1;
    end else if (!started_q) begin
      started_q <= 1'b1;
      delay_cnt_q <= pw_cycles;
      delay_busy_q <= pw_cycles != 24'h000000;
    end else if (delay_cnt_q > 24'h000001) begin
      delay_cnt_q <= delay_cnt_q - 24'h000001;
    end else begin
      delay_cnt_q <= 24'h000000;
      delay_busy_q <= 1'b0;
    end
  end
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign flash_wr_en = fwe_q;
  assign write_error_flag = err_q;
  assign wr_done = done_q;
  assign fetch_violation = fv_q;
  assign external_reset_pin = rst_pin_q;
  assign powerup_delay_timer = delay_busy_q;
  assign powerup_delay_select = pwsel_q;
  assign boot_end_addr = bend_q;
  assign code_protect_active = protect_q;
  // ****************************************
  // checks
  // ****************************************
  AST_RST_PIN_LVP: assert property (@(posedge mclk) disable iff (!rstn) lv_prog_on |=> external_reset_pin)
    else $error("reset pin not forced with low-voltage programming");
  AST_RST_PIN_PORT: assert property (@(posedge mclk) disable iff (!rstn)
    (!lv_prog_on && !cfg2_q[0]) |=> !external_reset_pin)
    else $error("reset pin not released to port");
  AST_APP_PROT: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && mif.region == cwp_pkg::CWP_RGN_APP && !cfg4_q[7]) |=> write_error_flag && !flash_wr_en)
    else $error("protected application write not refused");
  AST_STORE_PROT: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && mif.region == cwp_pkg::CWP_RGN_STORE && !cfg4_q[11]) |=> write_error_flag && !flash_wr_en)
    else $error("protected storage area write not refused");
  AST_CFG_PROT: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && mif.region == cwp_pkg::CWP_RGN_CFG && !cfg4_q[9]) |=> write_error_flag)
    else $error("protected configuration write not refused");
  AST_BOOT_PROT: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && mif.region == cwp_pkg::CWP_RGN_BOOT && !cfg4_q[8]) |=> write_error_flag && !flash_wr_en)
    else $error("protected boot write not refused");
  AST_ERR_FLAG: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && wr_refused) |=> (write_error_flag && !flash_wr_en))
    else $error("refused write did not flag error");
  AST_WRITE_OK: assert property (@(posedge mclk) disable iff (!rstn)
    (checking && !wr_refused && !wa_q[15]) |=> (flash_wr_en && !write_error_flag))
    else $error("accepted flash write not passed on");
  AST_PROT_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
    (!cfg4_q[7] && !bulk_erase) |=> !cfg4_q[7])
    else $error("protection bit set without erase");
  AST_PROTECT_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
    (protect_on && !bulk_erase) |=> protect_on)
    else $error("code protect removed without erase");
  AST_SIZE_LOCK: assert property (@(posedge mclk) disable iff (!rstn)
    (boot_en && !bulk_erase) |=> $stable(cfg4_q[2:0]))
    else $error("boot size changed while enabled");
  AST_LV_PROG_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
    (lv_session && lv_prog_on && !bulk_erase) |=> lv_prog_on)
    else $error("low-voltage enable cleared during session");
  AST_BOOT_CLAMP: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 boot_end_addr <= cwp_pkg::FLASH_HALF_END)
    else $error("boot end above half flash");
  AST_DELAY_SEL: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 powerup_delay_select == $past(cfg2_q[2:1]))
    else $error("delay select does not follow its field");
  AST_FETCH_STORE: assert property (@(posedge mclk) disable iff (!rstn)
    (fetch_req && store_en && fetch_addr >= 15'h0F80) |=> fetch_violation)
    else $error("fetch from storage area not flagged");
  AST_FETCH_FREE: assert property (@(posedge mclk) disable iff (!rstn)
    (fetch_req && !store_en) |=> !fetch_violation)
    else $error("fetch flagged with storage area disabled");
  AST_PROTECT_READ: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_req && rd_external && protect_on && rd_addr[15:12] == 4'h0) |=> rd_data == 14'h0000)
    else $error("protected external read not zero");
  AST_ID_READ: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_req && rd_id) |=> rd_data[13:12] == 2'h3)
    else $error("part word top bits wrong");
  AST_ID_CODE: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_req && rd_id) |=> rd_data[11:0] == cwp_pkg::PART_CODE)
    else $error("part code wrong");
  AST_REV_READ: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_req && rd_rev) |=> rd_data[13:12] == 2'h2)
    else $error("revision word top bits wrong");
endmodule // cwp_config_protect

// ==== verification/cwp_prog_model.sv ====
`timescale 1ns/1ps
// ****************************************
// programmer and flash array model
// ****************************************
module cwp_prog_model (
  // clock and answers
  input wire logic mclk,
  input wire logic wr_done,
  input wire logic rd_valid,
  input wire logic [13:0] rd_data,
  // requests
  output logic wr_req,
  output logic wr_external,
  output logic [15:0] wr_addr,
  output logic [13:0] wr_data,
  output logic bulk_erase,
  output logic rd_req,
  output logic rd_external,
  output logic [15:0] rd_addr,
  // flash array, a fixed pattern of the address
  output logic [13:0] flash_rd_data
);
  assign flash_rd_data = rd_addr[13:0] ^ 14'h1555;
  initial {wr_req, wr_external, wr_addr, wr_data, bulk_erase, rd_req, rd_external, rd_addr} = '0;
  // one request per call, so nothing lands while the sequencer is busy
  task automatic write_word(input logic [15:0] a, input logic [13:0] d, input logic ext, output bit ok);
    @(negedge mclk);
    wr_req = 1'b1;
    wr_external = ext;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_req = 1'b0;
    wr_addr = ~a; // released lines must not keep the old value
    wr_data = ~d;
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge mclk);
      ok = (wr_done === 1'b1);
    end
  endtask
  task automatic read_word(input logic [15:0] a, input logic ext, output logic [14:0] d, output bit ok);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_external = ext;
    rd_addr = a;
    @(negedge mclk);
    ok = (rd_valid === 1'b1);
    d = {1'b0, rd_data};
    rd_req = 1'b0;
    rd_addr = ~a;
  endtask
  task automatic erase();
    @(negedge mclk);
    bulk_erase = 1'b1;
    @(negedge mclk);
    bulk_erase = 1'b0;
  endtask
endmodule // cwp_prog_model

// ==== verification/config_word_protection_decode_tb_top.sv ====
`timescale 1ns/1ps
// ****************************************
// self-checking bench
// ****************************************
module config_word_protection_decode_tb_top;
  typedef struct packed {logic [15:0] a1; logic [13:0] d1; logic [15:0] a2; logic [13:0] d2; logic [3:0] sel;
    logic [14:0] want;} cwp_row_t;
  // word 4 written first except in rows 12 to 15, 18 to 21 and 31 to 34, debugger bit of word 2 kept at 1
  localparam cwp_row_t ROWS [38] = '{
    '{16'h800A,14'h3FF7,16'h800A,14'h3FF7,4'h0,15'h01FF},'{16'h800A,14'h3FF6,16'h800A,14'h3FF6,4'h0,15'h03FF},
    '{16'h800A,14'h3FF5,16'h800A,14'h3FF5,4'h0,15'h07FF},'{16'h800A,14'h3FF4,16'h800A,14'h3FF4,4'h0,15'h07FF},
    '{16'h800A,14'h3FF3,16'h800A,14'h3FF3,4'h0,15'h07FF},'{16'h800A,14'h3FF2,16'h800A,14'h3FF2,4'h0,15'h07FF},
    '{16'h800A,14'h3FF1,16'h800A,14'h3FF1,4'h0,15'h07FF},'{16'h800A,14'h3FF0,16'h800A,14'h3FF0,4'h0,15'h07FF},
    '{16'h800A,14'h3FFF,16'h8008,14'h3FFE,4'h1,15'h0001},'{16'h800A,14'h3FFF,16'h8008,14'h3FFF,4'h1,15'h0001},
    '{16'h800A,14'h1FFF,16'h8008,14'h3FFE,4'h1,15'h0000},'{16'h800A,14'h1FFF,16'h8008,14'h3FFF,4'h1,15'h0001},
    '{16'h8008,14'h3FF9,16'h8008,14'h3FF9,4'h2,15'h0000},'{16'h8008,14'h3FFB,16'h8008,14'h3FFB,4'h2,15'h0001},
    '{16'h8008,14'h3FFD,16'h8008,14'h3FFD,4'h2,15'h0002},'{16'h8008,14'h3FFF,16'h8008,14'h3FFF,4'h2,15'h0003},
    '{16'h800A,14'h347F,16'h800A,14'h3FFF,4'h3,15'h347F},'{16'h800A,14'h3FF7,16'h800A,14'h3FF6,4'h3,15'h3FF7},
    '{16'h800B,14'h3FFE,16'h800B,14'h3FFF,4'h5,15'h0001},'{16'h8006,14'h0000,16'h8006,14'h0000,4'h3,15'h3A5C},
    '{16'h8005,14'h0000,16'h8005,14'h0000,4'h3,15'h2042},'{16'h8009,14'h3FFF,16'h8009,14'h3FFF,4'h3,15'h0000},
    '{16'h800A,14'h3F7F,16'h0100,14'h0000,4'h4,15'h0001},'{16'h800A,14'h3FFF,16'h0100,14'h0000,4'h4,15'h0000},
    '{16'h800A,14'h37EF,16'h0FF0,14'h0000,4'h4,15'h0001},'{16'h800A,14'h37FF,16'h0FF0,14'h0000,4'h4,15'h0000},
    '{16'h800A,14'h3EF7,16'h0010,14'h0000,4'h4,15'h0001},'{16'h800A,14'h3EF7,16'h0300,14'h0000,4'h4,15'h0000},
    '{16'h800A,14'h3EFF,16'h0010,14'h0000,4'h4,15'h0000},'{16'h800A,14'h3DFF,16'h8008,14'h3FF9,4'h4,15'h0001},
    '{16'h800A,14'h3DFF,16'h8008,14'h3FF9,4'h3,15'h3FFF},'{16'h800B,14'h3FFE,16'h0100,14'h0000,4'h6,15'h0000},
    '{16'h800B,14'h3FFE,16'h0100,14'h0000,4'h3,15'h1455},'{16'h800B,14'h3FFE,16'h0100,14'h0000,4'h7,15'h0001},
    '{16'h800B,14'h3FFF,16'h0100,14'h0000,4'h7,15'h0000},'{16'h800A,14'h3FEF,16'h0F80,14'h0000,4'h8,15'h0001},
    '{16'h800A,14'h3FEF,16'h0F7F,14'h0000,4'h8,15'h0000},'{16'h800A,14'h3FFF,16'h0FFF,14'h0000,4'h8,15'h0000}};
  logic mclk, rstn, fetch_req, lv_session_pin, wr_req, wr_external, bulk_erase, rd_req, rd_external;
  logic [14:0] fetch_addr, boot_end_addr;
  logic [13:0] rd_data, wr_data, flash_rd_data;
  logic [15:0] wr_addr, rd_addr;
  logic [1:0] powerup_delay_select;
  logic rd_valid, flash_wr_en, write_error_flag, wr_done, fetch_violation, external_reset_pin;
  logic powerup_delay_timer, code_protect_active;
  int fail_count = 0;
  int checked = 0;
  cwp_config_protect dut (.mclk, .rstn, .wr_req, .wr_external, .wr_addr, .wr_data, .bulk_erase, .rd_req,
    .rd_external, .rd_addr, .flash_rd_data, .lv_session_pin, .fetch_req, .fetch_addr, .rd_data, .rd_valid,
    .flash_wr_en, .write_error_flag, .wr_done, .fetch_violation, .external_reset_pin, .powerup_delay_timer,
    .powerup_delay_select, .boot_end_addr, .code_protect_active);
  cwp_prog_model prog (.mclk, .wr_done, .rd_valid, .rd_data, .wr_req, .wr_external, .wr_addr, .wr_data,
    .bulk_erase, .rd_req, .rd_external, .rd_addr, .flash_rd_data);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string name, input logic [14:0] seen, input logic [14:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [13:0] d, input logic ext);
    bit ok;
    prog.write_word(a, d, ext, ok);
    check("write done", {14'h0, ok}, 15'h0001);
    if (!ok) complete_run();
  endtask
  task automatic rd(input logic [15:0] a, input logic ext, output logic [14:0] v);
    bit ok;
    prog.read_word(a, ext, v, ok);
    check("read valid", {14'h0, ok}, 15'h0001);
  endtask
  task automatic fetch(input logic [14:0] a, output logic [14:0] v);
    @(negedge mclk);
    fetch_req = 1'b1;
    fetch_addr = a;
    @(negedge mclk);
    v = {14'h0, fetch_violation};
    fetch_req = 1'b0;
  endtask
  task automatic check_reset(input string name);
    check(name, boot_end_addr, 15'h07FF);
    check(name, {11'h0, external_reset_pin, powerup_delay_timer, powerup_delay_select}, 15'h000F);
    check(name, {14'h0, code_protect_active}, 15'h0000);
  endtask
  initial begin
    logic [14:0] seen;
    cwp_row_t r;
    {rstn, fetch_req, fetch_addr, lv_session_pin} = '0;
    repeat (4) @(negedge mclk);
    check_reset("reset values");
    rstn = 1'b1;
    for (int i = 0; i < 38; i++) begin
      r = ROWS[i];
      prog.erase();
      wr(r.a1, r.d1, 1'b0);
      wr(r.a2, r.d2, r.sel == 4'h7);
      repeat (2) @(negedge mclk);
      case (r.sel)
        4'h0: seen = boot_end_addr;
        4'h1: seen = {14'h0, external_reset_pin};
        4'h2: seen = {13'h0, powerup_delay_select};
        4'h3: rd(r.a2, 1'b0, seen);
        4'h5: seen = {14'h0, code_protect_active};
        4'h6: rd(r.a2, 1'b1, seen);
        4'h8: fetch(r.a2[14:0], seen);
        default: seen = {14'h0, write_error_flag};
      endcase
      check($sformatf("row %0d", i), seen, r.want);
    end
    prog.erase();
    lv_session_pin = 1'b1; // session over the low-voltage path only, no high-voltage entry
    repeat (3) @(negedge mclk);
    wr(16'h800A, 14'h1FFF, 1'b1);
    rd(16'h800A, 1'b1, seen);
    check("clear in session", seen, 15'h3FFF);
    lv_session_pin = 1'b0;
    repeat (3) @(negedge mclk);
    wr(16'h800A, 14'h1FFF, 1'b1);
    rd(16'h800A, 1'b1, seen);
    check("clear outside session", seen, 15'h1FFF);
    wr(16'h800A, 14'h3FF7, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    check_reset("second reset");
    rstn = 1'b1;
    complete_run();
  end
endmodule // config_word_protection_decode_tb_top
